// ### dual_sar_adc_conversion_readout.v
/*
 conversion control and parallel readout for a dual simultaneous-sampling
 14-bit converter. assumes all pins are synchronous to clk; analog inputs
 arrive as digital sample words (unsigned, offset-binary scale).
*/
// Operation
// - convert-start falling edge holds both samples and starts both converters
// - both results are stored on the same clock edge that drops busy
// - first read gives input 1, second read gives input 2
// - pair-select level at start picks channel A (low) or B (high)
// - results leave on a 14-bit bus qualified by chip-select and read
// - conversion lasts 5.2 us fast, 10 us in auto-sleep
// - auto-sleep mode sleeps once the acquisition after conversion counts out; fast mode stays powered
// - track-and-holds return to track at conversion end
// - acquisition interval is 0.5 us
// - conversion timed internally, no host clock
// - busy rises on start edge, stays high until done
// - bus enabled and read taken only while read and chip-select low
// - twos complement for bipolar variants, straight binary for unipolar
`default_nettype none
`include "dual_sar_defines.vh"
module dual_sar_adc_conversion_readout #(
   parameter W = `RESULT_W,
   parameter BIPOLAR = 1
) (
   input wire clk,
   input wire reset,
   input wire convert_start_n,
   input wire pair_select,
   input wire autoSleep,
   input wire chipSelect_n,
   input wire read_n,
   input wire [W-1:0] chan_a_input_1,
   input wire [W-1:0] chan_a_input_2,
   input wire [W-1:0] chan_b_input_1,
   input wire [W-1:0] chan_b_input_2,
   output reg busy_q,
   output reg [W-1:0] resultBusOut_q,
   output reg resultBusOe_n_q,
   output reg tracking_q,
   output reg acquired_q,
   output reg asleep_q
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_CONV = 3'b010;
   localparam [2:0] ST_ACQ = 3'b100;
   localparam integer FAST_N = `CONV_FAST_CYC;
   localparam integer SLEEP_N = `CONV_SLEEP_CYC;
   localparam integer ACQ_N = `ACQ_CYC;
   // each conversion is spread over W+1 divider periods, W of them deciding bits
   localparam integer FAST_STEP_N = FAST_N / (W + 1);
   localparam integer SLEEP_STEP_N = SLEEP_N / (W + 1);
   localparam [`CNT_W-1:0] FAST_CYC = FAST_N[`CNT_W-1:0];
   localparam [`CNT_W-1:0] SLEEP_CYC = SLEEP_N[`CNT_W-1:0];
   localparam [`CNT_W-1:0] ACQ_CYC = ACQ_N[`CNT_W-1:0];
   localparam [`CNT_W-1:0] FAST_STEP = FAST_STEP_N[`CNT_W-1:0];
   localparam [`CNT_W-1:0] SLEEP_STEP = SLEEP_STEP_N[`CNT_W-1:0];
   reg [2:0] state_q;
   reg [`CNT_W-1:0] count_q;
   reg [`CNT_W-1:0] stepEvery_q;
   reg [`CNT_W-1:0] stepCnt_q;
   reg convPrev_q;
   reg sleepMode_q;
   reg [W-1:0] held1_q;
   reg [W-1:0] held2_q;
   reg [W-1:0] result1_q;
   reg [W-1:0] result2_q;
   reg readSecond_q;
   reg readPrev_q;
   wire startEdge;
   wire readActive;
   wire step;
   wire [W-1:0] code1;
   wire [W-1:0] code2;
   wire [`CNT_W-1:0] convLen;
   wire [`CNT_W-1:0] stepLen;
   wire convDone;
   wire acqDone;
   assign startEdge = convPrev_q & ~convert_start_n & ~busy_q;
   assign readActive = ~read_n & ~chipSelect_n;
   assign step = (state_q == ST_CONV) && (stepCnt_q == {`CNT_W{1'b0}});
   // total length and step spacing by mode
   assign convLen = autoSleep ? SLEEP_CYC : FAST_CYC;
   assign stepLen = autoSleep ? SLEEP_STEP : FAST_STEP;
   assign convDone = (state_q == ST_CONV) && (count_q == {`CNT_W{1'b0}});
   assign acqDone = (state_q == ST_ACQ) && (count_q == {`CNT_W{1'b0}});
   // converters stepped from an internal divider
   // bipolar coding flips the msb inside each converter
   sar_channel #(.W(W)) conv1 (
      .clk(clk),
      .reset(reset),
      .start(startEdge),
      .step(step),
      .heldSample(held1_q),
      .twosComp(BIPOLAR != 0),
      .code_q(code1)
   );
   sar_channel #(.W(W)) conv2 (
      .clk(clk),
      .reset(reset),
      .start(startEdge),
      .step(step),
      .heldSample(held2_q),
      .twosComp(BIPOLAR != 0),
      .code_q(code2)
   );
   // edge register idles high like the pin, so reset makes no false edge
   always @(posedge clk) begin
      if (reset) begin
         convPrev_q <= 1'b1;
      end else begin
         convPrev_q <= convert_start_n;
      end
   end
   // sequencer: idle, converting, acquiring
   always @(posedge clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         count_q <= {`CNT_W{1'b0}};
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (startEdge) begin
                  count_q <= convLen - 1'b1;
                  state_q <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (convDone) begin
                  count_q <= ACQ_CYC - 1'b1;
                  state_q <= ST_ACQ;
               end else begin
                  count_q <= count_q - 1'b1;
               end
            end
            ST_ACQ: begin
               // an early start is taken; settling before it is the host's duty
               if (startEdge) begin
                  count_q <= convLen - 1'b1;
                  state_q <= ST_CONV;
               end else if (acqDone) begin
                  state_q <= ST_IDLE;
               end else begin
                  count_q <= count_q - 1'b1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
   // bit steps from an internal divider
   always @(posedge clk) begin
      if (reset) begin
         stepEvery_q <= {`CNT_W{1'b0}};
         stepCnt_q <= {`CNT_W{1'b0}};
      end else if (startEdge) begin
         stepEvery_q <= stepLen;
         stepCnt_q <= stepLen;
      end else if (state_q == ST_CONV) begin
         stepCnt_q <= step ? stepEvery_q : stepCnt_q - 1'b1;
      end
   end
   // pair chosen by level at start
   always @(posedge clk) begin
      if (reset) begin
         held1_q <= {W{1'b0}};
         held2_q <= {W{1'b0}};
         sleepMode_q <= 1'b0;
      end else if (startEdge) begin
         held1_q <= pair_select ? chan_b_input_1 : chan_a_input_1;
         held2_q <= pair_select ? chan_b_input_2 : chan_a_input_2;
         sleepMode_q <= autoSleep;
      end
   end
   always @(posedge clk) begin
      if (reset) begin
         result1_q <= {W{1'b0}};
         result2_q <= {W{1'b0}};
      end else if (convDone) begin
         result1_q <= code1;
         result2_q <= code2;
      end
   end
   // status flags; a start in the cycle acquisition ends wins, as it begins new work
   always @(posedge clk) begin
      if (reset) begin
         busy_q <= 1'b0;
         tracking_q <= 1'b1;
         acquired_q <= 1'b1;
         asleep_q <= 1'b0;
      end else if (startEdge) begin
         busy_q <= 1'b1;
         tracking_q <= 1'b0;
         acquired_q <= 1'b0;
         asleep_q <= 1'b0;
      end else if (convDone) begin
         busy_q <= 1'b0;
         tracking_q <= 1'b1;
      end else if (acqDone) begin
         acquired_q <= 1'b1;
         asleep_q <= sleepMode_q;
      end
   end
   // readout: pointer advances on the rising edge that ends each read
   always @(posedge clk) begin
      if (reset) begin
         readSecond_q <= 1'b0;
         readPrev_q <= 1'b0;
         resultBusOut_q <= {W{1'b0}};
         resultBusOe_n_q <= 1'b1;
      end else begin
         readPrev_q <= readActive;
         // pointer back to input 1 at start
         if (startEdge) begin
            readSecond_q <= 1'b0;
         end else if (readPrev_q && !readActive) begin
            readSecond_q <= ~readSecond_q;
         end
         // read order selects result; drive 14-bit bus
         resultBusOut_q <= readSecond_q ? result2_q : result1_q;
         // bus released when either strobe high
         resultBusOe_n_q <= ~readActive;
      end
   end
endmodule
`default_nettype wire

// ### dual_sar_defines.vh
/*
 constants for the dual simultaneous-sampling converter control block.
 assumes a 25 MHz system clock; included by its bare name.
*/
`ifndef DUAL_SAR_DEFINES_VH
`define DUAL_SAR_DEFINES_VH
`define CLK_PERIOD_NS 40
`define CONV_FAST_NS 5200
`define CONV_SLEEP_NS 10000
`define ACQ_NS 500
`define CONV_FAST_CYC ((`CONV_FAST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_SLEEP_CYC ((`CONV_SLEEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACQ_CYC ((`ACQ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESULT_W 14
`define CNT_W 9
`endif

// ### sar_channel.v
/*
 one successive-approximation converter: binary search against a digital
 stand-in of the held sample, one bit per step. assumes start is a pulse.
*/
`default_nettype none
module sar_channel #(
   parameter W = 14
) (
   input wire clk,
   input wire reset,
   input wire start,
   input wire step,
   input wire [W-1:0] heldSample,
   input wire twosComp,
   output reg [W-1:0] code_q
);
   reg [W-1:0] trial_q;
   reg [W-1:0] bitMask_q;
   wire [W-1:0] trialBits;
   assign trialBits = trial_q | bitMask_q;
   always @(posedge clk) begin
      if (reset) begin
         trial_q <= {W{1'b0}};
         bitMask_q <= {W{1'b0}};
         code_q <= {W{1'b0}};
      end else if (start) begin
         trial_q <= {W{1'b0}};
         bitMask_q <= {1'b1, {(W-1){1'b0}}};
      end else if (step && (bitMask_q != {W{1'b0}})) begin
         if (trialBits <= heldSample) begin
            trial_q <= trialBits;
         end
         bitMask_q <= bitMask_q >> 1;
         // result latched at the final bit; offset binary flips msb for bipolar
         if (bitMask_q[0]) begin
            code_q <= (trialBits <= heldSample) ? trialBits : trial_q;
            if (twosComp) begin
               code_q[W-1] <= ~((trialBits <= heldSample) ? trialBits[W-1] : trial_q[W-1]);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### sar_chk.sv
/* port assertions for the converter control block.
   assumes binding into its top module. */
`default_nettype none
module sar_chk (
   input wire logic clk,
   input wire logic reset,
   input wire logic convert_start_n,
   input wire logic autoSleep,
   input wire logic chipSelect_n,
   input wire logic read_n,
   input wire logic busy_q,
   input wire logic resultBusOe_n_q,
   input wire logic tracking_q,
   input wire logic acquired_q,
   input wire logic asleep_q
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   a_busy_rise: assert property ($fell(convert_start_n) && !busy_q |=> busy_q)
      else $error("busy late");
   a_conv_fast: assert property (
      $rose(busy_q) && !$past(autoSleep) |-> ##129 busy_q ##1 !busy_q) else $error("fast len");
   a_conv_sleep: assert property (
      $rose(busy_q) && $past(autoSleep) |-> ##249 busy_q ##1 !busy_q) else $error("sleep len");
   a_hold_busy: assert property (busy_q |-> !tracking_q) else $error("tracking");
   a_track_end: assert property ($fell(busy_q) |-> tracking_q) else $error("no track");
   // acquisition is 500 ns rounded up to 13 whole clocks
   a_acq_wait: assert property (
      $rose(tracking_q) |-> !acquired_q [*8] ##1 !acquired_q [*5] ##1 acquired_q)
      else $error("acq len");
   // asleep follows the mode latched at start once acquisition has counted out
   a_sleep_entry: assert property (
      $rose(busy_q) && $past(autoSleep) |-> ##263 (acquired_q && asleep_q))
      else $error("no sleep");
   a_fast_awake: assert property (
      $rose(busy_q) && !$past(autoSleep) |-> ##143 (acquired_q && !asleep_q))
      else $error("slept in fast mode");
   a_bus_on: assert property (
      (!chipSelect_n && !read_n) [*2] |-> !resultBusOe_n_q) else $error("bus off");
   a_bus_off: assert property (
      (chipSelect_n || read_n) [*2] |-> resultBusOe_n_q) else $error("bus on");
   cover property ($fell(busy_q) && autoSleep);
   cover property ($fell(busy_q) && !autoSleep);
   cover property ($rose(resultBusOe_n_q));
   cover property ($rose(asleep_q));
endmodule
bind dual_sar_adc_conversion_readout sar_chk u_chk (.clk(clk), .reset(reset),
   .convert_start_n(convert_start_n), .autoSleep(autoSleep), .chipSelect_n(chipSelect_n),
   .read_n(read_n), .busy_q(busy_q), .resultBusOe_n_q(resultBusOe_n_q),
   .tracking_q(tracking_q), .acquired_q(acquired_q), .asleep_q(asleep_q));
`default_nettype wire

// ### sar_host.sv
/* host model: pulses the convert strobe and reads results.
   assumes registered busy, acquired and enable outputs. */
`default_nettype none
`include "dual_sar_defines.vh"
module sar_host (
   input wire logic clk,
   input wire logic busy_q,
   input wire logic acquired_q,
   input wire logic resultBusOe_n_q,
   input wire logic [13:0] resultBusOut_q,
   output var logic convert_start_n,
   output var logic chipSelect_n,
   output var logic read_n
);
   initial begin
      convert_start_n = 1'b1;
      chipSelect_n = 1'b1;
      read_n = 1'b1;
   end
   // pair or inputs may just have moved: settle, then wait for acquisition
   task automatic start();
      int n = 0;
      repeat (`ACQ_CYC) @(negedge clk);
      while (!acquired_q && n++ < 99) @(negedge clk);
      @(negedge clk) convert_start_n = 1'b0;
      @(negedge clk) convert_start_n = 1'b1;
   endtask
   // read only once busy has fallen
   task automatic readWord(output logic [13:0] d);
      int n = 0;
      while (busy_q && n++ < 300) @(negedge clk);
      chipSelect_n = 1'b0;
      read_n = 1'b0;
      do @(negedge clk); while (resultBusOe_n_q && n++ < 320);
      d = resultBusOut_q;
      chipSelect_n = 1'b1;
      read_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ### dual_sar_adc_conversion_readout_test.sv
/* self-checking bench: random conversions in both modes.
   assumes default width; a second instance covers straight binary. */
`default_nettype none
module dual_sar_adc_conversion_readout_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic pair_select = 1'b0;
   logic autoSleep = 1'b0;
   logic [13:0] smp [4] = '{default: 14'h0000};
   logic [13:0] held [4];
   logic [13:0] resultBusOut_q, got;
   logic convert_start_n, chipSelect_n, read_n, busy_q, resultBusOe_n_q, acquired_q;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int ps;
   int nr;
   logic [13:0] expRaw, uniBus, uniGot;
   logic uniOe_n;
   always #20 clk = ~clk;
   dual_sar_adc_conversion_readout u_dut (.clk(clk), .reset(reset),
      .convert_start_n(convert_start_n), .pair_select(pair_select), .autoSleep(autoSleep),
      .chipSelect_n(chipSelect_n), .read_n(read_n), .chan_a_input_1(smp[0]),
      .chan_a_input_2(smp[1]), .chan_b_input_1(smp[2]), .chan_b_input_2(smp[3]),
      .busy_q(busy_q), .resultBusOut_q(resultBusOut_q), .resultBusOe_n_q(resultBusOe_n_q),
      .tracking_q(), .acquired_q(acquired_q), .asleep_q());
   sar_host u_host (.clk(clk), .busy_q(busy_q), .acquired_q(acquired_q),
      .resultBusOe_n_q(resultBusOe_n_q), .resultBusOut_q(resultBusOut_q),
      .convert_start_n(convert_start_n), .chipSelect_n(chipSelect_n), .read_n(read_n));
   dual_sar_adc_conversion_readout #(.BIPOLAR(0)) u_dut_uni (.clk(clk), .reset(reset),
      .convert_start_n(convert_start_n), .pair_select(pair_select), .autoSleep(autoSleep),
      .chipSelect_n(chipSelect_n), .read_n(read_n), .chan_a_input_1(smp[0]),
      .chan_a_input_2(smp[1]), .chan_b_input_1(smp[2]), .chan_b_input_2(smp[3]),
      .busy_q(), .resultBusOut_q(uniBus), .resultBusOe_n_q(uniOe_n),
      .tracking_q(), .acquired_q(), .asleep_q());
   // the unipolar twin shares every strobe; keep what its bus showed while enabled
   always @(negedge clk) begin
      if (!uniOe_n) begin
         uniGot <= uniBus;
      end
   end
   // bipolar coding flips the msb of the unsigned sample scale
   function automatic logic [13:0] coded(input logic [13:0] s);
      return s ^ 14'h2000;
   endfunction
   task automatic end_sim();
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      if (++cycles == 20000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(32'h3f34));
      repeat (5) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 12; i++) begin
         pair_select = 1'($urandom);
         autoSleep = i[1];
         foreach (smp[k]) smp[k] = (i < 2) ? {14{i[0]}} : 14'($urandom);
         held = smp;
         ps = pair_select;
         u_host.start();
         // inputs and pair move after the start; results must not follow them
         foreach (smp[k]) smp[k] = ~held[k];
         pair_select = ~pair_select;
         // a third read wraps to input 1; a lone read must not leak into the next conversion
         nr = (i == 4) ? 3 : (i == 6) ? 1 : 2;
         for (int r = 0; r < nr; r++) begin
            u_host.readWord(got);
            expRaw = held[2 * ps + r % 2];
            n_tests++;
            if (got !== coded(expRaw)) begin
               bad_count++;
               $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, coded(expRaw));
            end
            n_tests++;
            if (uniGot !== expRaw) begin
               bad_count++;
               $display("CHECK FAILED t=%0t got=%h exp=%h", $time, uniGot, expRaw);
            end
         end
      end
      end_sim();
   end
endmodule
`default_nettype wire
